// [suspend_wake.sv]
// Suspend entry, wake source selection, ring counting and APB register file
//
// Register access over APB was chosen for this implementation.
`timescale 1ns/1ns
// How it works
// - Misc bit 6 high selects the half-width suspend refresh pulse, low the normal one.
// - Wake group, ring count or wake pin, any one or more, ends suspend.
// - Two enable registers choose which interrupt lines form the wake group.
// - Wake group lines only wake when the global group enable bit is one.
// - SYSTEM_MANAGEMENT_INTERRUPT comes from latched external PM lines or the wake event, each enabled.
// - All line wake enables reset to disabled.
// - Enabled lines wake on rising edge; IRQ8 alone wakes on falling edge.
// - Ring transitions counted; wake event when count exceeds threshold and enabled.
// - Ring input is sampled on a 32 kHz enable.
// - Wake pin always wakes, no enable, and raises the wake event.
// - Low enable bits: EPMI2, EPMI1, IRQ8, IRQ7, IRQ5, IRQ4, IRQ3, IRQ1.
// - High enable bits: EPMI4, EPMI3, IRQ15, IRQ14, IRQ12, IRQ11, IRQ10, IRQ9.
// - Three read-only source bits report ring, group or pin as wake cause.
// - After a group wake, enable registers read latched lines until the wake event clear or a start-suspend write is made.
// - Writing one to the start-suspend bit enters suspend.
module suspend_wake #(
    parameter int SAMPLE_DIV = suspend_wake_pkg::SAMPLE_DIV
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // APB slave
    input wire logic [11:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Wake sources
    input wire logic [15:0] irqLine,
    input wire logic [3:0] externalPmInterrupt,
    input wire logic ringIndicatorInput,
    input wire logic suspendWakePin_n,
    // Status outputs
    output logic suspendActive,
    output logic wakePmEvent,
    output logic systemManagementInterrupt,
    output logic shortRefreshPulse,
    output logic irq
);
    // ========================================
    // Register decode
    function automatic logic hit(input logic [11:0] addr, input logic [9:0] idx);
        hit = (addr[11:2] == idx) && (addr[1:0] == 2'h0);
    endfunction

    function automatic logic mapped(input logic [11:0] addr);
        mapped = hit(addr, suspend_wake_pkg::IDX_MISC) || hit(addr, suspend_wake_pkg::IDX_SUSPEND)
            || hit(addr, suspend_wake_pkg::IDX_EXTERNAL_PM_INTERRUPT_SMI) || hit(addr, suspend_wake_pkg::IDX_WAKE_SMI)
            || hit(addr, suspend_wake_pkg::IDX_EVENT) || hit(addr, suspend_wake_pkg::IDX_RESUME_CTRL)
            || hit(addr, suspend_wake_pkg::IDX_EN_LOW) || hit(addr, suspend_wake_pkg::IDX_SOURCE)
            || hit(addr, suspend_wake_pkg::IDX_EN_HIGH) || hit(addr, suspend_wake_pkg::IDX_IRQ_STATUS)
            || hit(addr, suspend_wake_pkg::IDX_IRQ_MASK);
    endfunction

    // ========================================
    // State
    suspend_wake_pkg::power_state_t state, next_state;
    logic [7:0] miscControl, next_miscControl;
    logic [7:0] resumeControl, next_resumeControl;
    logic [15:0] lineEnable, next_lineEnable;
    logic [15:0] latchedLines, next_latchedLines;
    logic [2:0] wakeSource, next_wakeSource;
    logic wakeEvent, next_wakeEvent;
    logic [3:0] epmiSmiEnable, next_epmiSmiEnable;
    logic wakeSmiEnable, next_wakeSmiEnable;
    logic [1:0] irqStatus, next_irqStatus;
    logic [1:0] irqMask, next_irqMask;
    logic [4:0] ringCount, next_ringCount;
    logic ringSample, next_ringSample;
    logic [12:0] divCount, next_divCount;
    logic system_management_interrupt, next_smi;
    logic [31:0] readData, next_readData;

    // ========================================
    // Wake line vector in enable register layout
    logic [15:0] lineVec;
    logic [17:0] rawIn;
    logic [17:0] sync1, sync2, sync3;
    logic [17:0] stable, next_stable;

    assign lineVec = {externalPmInterrupt[3], externalPmInterrupt[2], irqLine[15], irqLine[14],
                      irqLine[12], irqLine[11], irqLine[10], irqLine[9],
                      externalPmInterrupt[1], externalPmInterrupt[0], irqLine[8], irqLine[7],
                      irqLine[5], irqLine[4], irqLine[3], irqLine[1]};
    assign rawIn = {suspendWakePin_n, ringIndicatorInput, lineVec};

    // ========================================
    // Input synchronisers
    genvar gi;
    generate
        for (gi = 0; gi < 18; gi++) begin : g_sync
            // A change counts only once two later stages agree
            assign next_stable[gi] = (sync2[gi] == sync3[gi]) ? sync2[gi] : stable[gi];
            always_ff @(posedge clk) begin
                if (!rst_n) begin
                    sync1[gi] <= suspend_wake_pkg::SYNC_INIT[gi];
                    sync2[gi] <= suspend_wake_pkg::SYNC_INIT[gi];
                    sync3[gi] <= suspend_wake_pkg::SYNC_INIT[gi];
                    stable[gi] <= suspend_wake_pkg::SYNC_INIT[gi];
                end else begin
                    sync1[gi] <= rawIn[gi];
                    sync2[gi] <= sync1[gi];
                    sync3[gi] <= sync2[gi];
                    stable[gi] <= next_stable[gi];
                end
            end
        end
    endgenerate

    // ========================================
    // Edge detection
    logic [15:0] lineRise, lineFall, lineEdge;
    logic pinFall, sampleTick, ringToggle;

    always_comb begin
        lineRise = next_stable[15:0] & ~stable[15:0];
        lineFall = ~next_stable[15:0] & stable[15:0];
        lineEdge = lineRise;
        lineEdge[suspend_wake_pkg::IRQ8_POS] = lineFall[suspend_wake_pkg::IRQ8_POS];
    end

    assign pinFall = stable[suspend_wake_pkg::SYNC_PIN_POS] & ~next_stable[suspend_wake_pkg::SYNC_PIN_POS];
    // 32 kHz sampling enable from the system clock
    assign sampleTick = (divCount == 13'(SAMPLE_DIV - 1));
    // Fast chatter between ticks is lost by design
    assign ringToggle = sampleTick && (stable[suspend_wake_pkg::SYNC_RING_POS] != ringSample);

    // ========================================
    // APB strobes
    logic wrAccess, setupRead;
    logic [7:0] wrByte;
    logic [15:0] groupHit;
    logic ringHit, groupAny, anyWake;

    assign wrAccess = psel && penable && pwrite;
    assign setupRead = psel && !penable && !pwrite;
    assign wrByte = pwdata[7:0];

    // ========================================
    // Next-state logic
    always_comb begin
        next_state = state;
        next_miscControl = miscControl;
        next_resumeControl = resumeControl;
        next_lineEnable = lineEnable;
        next_latchedLines = latchedLines;
        next_wakeSource = wakeSource;
        next_wakeEvent = wakeEvent;
        next_epmiSmiEnable = epmiSmiEnable;
        next_wakeSmiEnable = wakeSmiEnable;
        next_irqStatus = irqStatus;
        next_irqMask = irqMask;
        next_ringCount = ringCount;
        next_ringSample = sampleTick ? stable[suspend_wake_pkg::SYNC_RING_POS] : ringSample;
        next_divCount = sampleTick ? 13'h0000 : divCount + 13'h0001;
        next_readData = readData;
        groupHit = lineEdge & lineEnable
            & {16{resumeControl[suspend_wake_pkg::GROUP_EN_BIT]}};
        groupAny = |groupHit;
        ringHit = resumeControl[suspend_wake_pkg::RING_EN_BIT]
            && (ringCount > {1'b0, resumeControl[3:0]});
        anyWake = (state == suspend_wake_pkg::ST_SUSPENDED) && (groupAny || ringHit || pinFall);

        // Register writes
        if (wrAccess) begin
            if (hit(paddr, suspend_wake_pkg::IDX_MISC)) begin
                next_miscControl = wrByte;
            end
            if (hit(paddr, suspend_wake_pkg::IDX_RESUME_CTRL)) begin
                next_resumeControl = wrByte;
            end
            if (hit(paddr, suspend_wake_pkg::IDX_EN_LOW)) begin
                next_lineEnable[7:0] = wrByte;
            end
            if (hit(paddr, suspend_wake_pkg::IDX_EN_HIGH)) begin
                next_lineEnable[15:8] = wrByte;
            end
            if (hit(paddr, suspend_wake_pkg::IDX_EXTERNAL_PM_INTERRUPT_SMI)) begin
                next_epmiSmiEnable = wrByte[3:0];
            end
            if (hit(paddr, suspend_wake_pkg::IDX_WAKE_SMI)) begin
                next_wakeSmiEnable = wrByte[suspend_wake_pkg::WAKE_SMI_BIT];
            end
            if (hit(paddr, suspend_wake_pkg::IDX_IRQ_MASK)) begin
                next_irqMask = wrByte[1:0];
            end
            if (hit(paddr, suspend_wake_pkg::IDX_IRQ_STATUS)) begin
                next_irqStatus = irqStatus & ~wrByte[1:0];
            end
            if (hit(paddr, suspend_wake_pkg::IDX_EVENT) && wrByte[suspend_wake_pkg::WAKE_CLEAR_BIT]) begin
                next_wakeEvent = 1'b0;
                next_latchedLines = 16'h0000;
            end
            if (hit(paddr, suspend_wake_pkg::IDX_SUSPEND) && wrByte[suspend_wake_pkg::START_SUSPEND_BIT]) begin
                next_state = suspend_wake_pkg::ST_SUSPENDED;
                next_ringCount = 5'h00;
                next_wakeSource = 3'h0;
                next_irqStatus[suspend_wake_pkg::EVT_SUSPEND_BIT] = 1'b1;
            end
        end

        // Ring transitions counted only while suspended, saturating
        if (state == suspend_wake_pkg::ST_SUSPENDED && ringToggle && ringCount != 5'h1F) begin
            next_ringCount = ringCount + 5'h01;
        end

        // Wake events win over a clear in the same cycle
        if (anyWake) begin
            next_state = suspend_wake_pkg::ST_ACTIVE;
            next_wakeEvent = 1'b1;
            next_wakeSource[suspend_wake_pkg::SRC_RING_BIT] = ringHit;
            next_wakeSource[suspend_wake_pkg::SRC_GROUP_BIT] = groupAny;
            next_wakeSource[suspend_wake_pkg::SRC_PIN_BIT] = pinFall;
            next_latchedLines = groupHit;
            next_irqStatus[suspend_wake_pkg::EVT_RESUME_BIT] = 1'b1;
        end

        // SYSTEM_MANAGEMENT_INTERRUPT from the wake event or latched external PM lines
        next_smi = (next_wakeEvent && next_wakeSmiEnable)
            || |({next_latchedLines[15:14], next_latchedLines[7:6]} & next_epmiSmiEnable);

        // Read data captured in the setup phase
        if (setupRead) begin
            next_readData = 32'h0000_0000;
            if (hit(paddr, suspend_wake_pkg::IDX_MISC)) begin
                next_readData[7:0] = miscControl;
            end
            if (hit(paddr, suspend_wake_pkg::IDX_RESUME_CTRL)) begin
                next_readData[7:0] = resumeControl;
            end
            if (hit(paddr, suspend_wake_pkg::IDX_EN_LOW)) begin
                next_readData[7:0] = (wakeEvent && wakeSource[suspend_wake_pkg::SRC_GROUP_BIT])
                    ? latchedLines[7:0] : lineEnable[7:0];
            end
            if (hit(paddr, suspend_wake_pkg::IDX_EN_HIGH)) begin
                next_readData[7:0] = (wakeEvent && wakeSource[suspend_wake_pkg::SRC_GROUP_BIT])
                    ? latchedLines[15:8] : lineEnable[15:8];
            end
            if (hit(paddr, suspend_wake_pkg::IDX_SOURCE)) begin
                next_readData[2:0] = wakeSource;
            end
            if (hit(paddr, suspend_wake_pkg::IDX_SUSPEND)) begin
                next_readData[suspend_wake_pkg::PENDING_BIT] = wakeEvent;
            end
            if (hit(paddr, suspend_wake_pkg::IDX_EVENT)) begin
                next_readData[suspend_wake_pkg::WAKE_CLEAR_BIT] = wakeEvent;
            end
            if (hit(paddr, suspend_wake_pkg::IDX_EXTERNAL_PM_INTERRUPT_SMI)) begin
                next_readData[3:0] = epmiSmiEnable;
            end
            if (hit(paddr, suspend_wake_pkg::IDX_WAKE_SMI)) begin
                next_readData[suspend_wake_pkg::WAKE_SMI_BIT] = wakeSmiEnable;
            end
            if (hit(paddr, suspend_wake_pkg::IDX_IRQ_STATUS)) begin
                next_readData[1:0] = irqStatus;
            end
            if (hit(paddr, suspend_wake_pkg::IDX_IRQ_MASK)) begin
                next_readData[1:0] = irqMask;
            end
        end
    end

    // ========================================
    // Registers
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            state <= suspend_wake_pkg::ST_ACTIVE;
            miscControl <= suspend_wake_pkg::RESET_BYTE;
            resumeControl <= suspend_wake_pkg::RESET_BYTE;
            lineEnable <= {suspend_wake_pkg::RESET_BYTE, suspend_wake_pkg::RESET_BYTE};
            latchedLines <= 16'h0000;
            wakeSource <= 3'h0;
            wakeEvent <= 1'b0;
            epmiSmiEnable <= 4'h0;
            wakeSmiEnable <= 1'b0;
            irqStatus <= 2'h0;
            irqMask <= 2'h0;
            ringCount <= 5'h00;
            ringSample <= 1'b0;
            divCount <= 13'h0000;
            system_management_interrupt <= 1'b0;
            readData <= 32'h0000_0000;
        end else begin
            state <= next_state;
            miscControl <= next_miscControl;
            resumeControl <= next_resumeControl;
            lineEnable <= next_lineEnable;
            latchedLines <= next_latchedLines;
            wakeSource <= next_wakeSource;
            wakeEvent <= next_wakeEvent;
            epmiSmiEnable <= next_epmiSmiEnable;
            wakeSmiEnable <= next_wakeSmiEnable;
            irqStatus <= next_irqStatus;
            irqMask <= next_irqMask;
            ringCount <= next_ringCount;
            ringSample <= next_ringSample;
            divCount <= next_divCount;
            system_management_interrupt <= next_smi;
            readData <= next_readData;
        end
    end

    // ========================================
    // Outputs
    assign prdata = readData;
    assign pready = 1'b1;
    assign pslverr = psel && penable && !mapped(paddr);
    assign suspendActive = (state == suspend_wake_pkg::ST_SUSPENDED);
    assign wakePmEvent = wakeEvent;
    assign systemManagementInterrupt = system_management_interrupt;
    assign shortRefreshPulse = miscControl[suspend_wake_pkg::SHORT_PULSE_BIT];
    assign irq = |(irqStatus & irqMask);
endmodule

// [suspend_wake_bench.sv]
// Self-checking bench for the suspend wake block
`timescale 1ns/1ns
module suspend_wake_bench;
    localparam int DIV = 8;
    localparam int LIMIT = 40000;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [31:0] pwdata = 32'h00000000;
    logic [31:0] prdata, rd;
    logic pready, pslverr, rdErr, suspendActive, wakePmEvent, systemManagementInterrupt, shortRefreshPulse, irq;
    logic [15:0] irqLine;
    logic [3:0] externalPmInterrupt;
    logic ringIndicatorInput, suspendWakePin_n;
    int errTotal = 0;
    int nTests = 0;
    int cycles = 0;
    int seed = 75;
    // Wake line behind each enable bit, low register then high
    int linePos [16] = '{1, 3, 4, 5, 7, 8, 16, 17, 9, 10, 11, 12, 14, 15, 18, 19};
    logic [9:0] regIdx [4] = '{suspend_wake_pkg::IDX_MISC, suspend_wake_pkg::IDX_RESUME_CTRL,
        suspend_wake_pkg::IDX_EN_LOW, suspend_wake_pkg::IDX_EN_HIGH};

    suspend_wake #(.SAMPLE_DIV(DIV)) i_suspend_wake (.clk(clk), .rst_n(rst_n), .paddr(paddr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .irqLine(irqLine), .externalPmInterrupt(externalPmInterrupt), .ringIndicatorInput(ringIndicatorInput),
        .suspendWakePin_n(suspendWakePin_n), .suspendActive(suspendActive), .wakePmEvent(wakePmEvent),
        .systemManagementInterrupt(systemManagementInterrupt), .shortRefreshPulse(shortRefreshPulse), .irq(irq));
    wake_source_model #(.HOLD_UNIT(2 * DIV)) i_wake_source_model (.clk(clk), .irqLine(irqLine),
        .externalPmInterrupt(externalPmInterrupt), .ringIndicatorInput(ringIndicatorInput),
        .suspendWakePin_n(suspendWakePin_n));

    always #2 clk = !clk;
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == LIMIT) begin
            errTotal = errTotal + 1;
            giveVerdict();
        end
    end
    // ========================================
    // Bus and compare helpers
    function automatic logic [11:0] adr(input logic [9:0] idx);
        return {idx, 2'b00};
    endfunction
    task automatic apb(input logic [11:0] a, input logic wr, input logic [7:0] d);
        @(posedge clk);
        psel <= 1'b1;
        paddr <= a;
        pwrite <= wr;
        pwdata <= {24'h000000, d};
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1) @(posedge clk);
        rd = prdata;
        rdErr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
        nTests++;
        if (got !== exp) begin
            errTotal++;
            $display("[FAIL] %0t %s got %h expected %h", $time, what, got, exp);
        end
    endtask
    task automatic enterSuspend();
        apb(adr(suspend_wake_pkg::IDX_SUSPEND), 1'b1, 8'h01);
        @(negedge clk);
        check(suspendActive, 1, "suspend entry");
    endtask
    // Sampled on the falling edge so registered outputs have settled
    task automatic waitWake();
        int n;
        n = 0;
        while (suspendActive !== 1'b0 && n < 40) begin
            @(negedge clk);
            n++;
        end
    endtask
    task automatic groupCase(input int k, input logic ge);
        int pos, o;
        pos = linePos[k];
        o = linePos[(k + 1 + (($random(seed) & 32'h7FFFFFFF) % 15)) % 16];
        apb(adr(suspend_wake_pkg::IDX_EN_LOW), 1'b1, k < 8 ? 8'(1 << k) : 8'h00);
        apb(adr(suspend_wake_pkg::IDX_EN_HIGH), 1'b1, k >= 8 ? 8'(1 << (k - 8)) : 8'h00);
        apb(adr(suspend_wake_pkg::IDX_RESUME_CTRL), 1'b1, ge ? 8'h20 : 8'h00);
        enterSuspend();
        i_wake_source_model.set_line(o, o == 8 ? 1'b0 : 1'b1);
        repeat (12) @(negedge clk);
        check(suspendActive, 1, "disabled line woke");
        i_wake_source_model.set_line(pos, pos == 8 ? 1'b0 : 1'b1);
        waitWake();
        check(suspendActive, !ge, "group wake");
        if (ge) begin
            apb(adr(suspend_wake_pkg::IDX_SOURCE), 1'b0, 8'h00);
            check(rd, 2, "group source");
            check(systemManagementInterrupt, pos >= 16, "pm line smi");
            apb(adr(k < 8 ? suspend_wake_pkg::IDX_EN_LOW : suspend_wake_pkg::IDX_EN_HIGH), 1'b0, 8'h00);
            check(rd, 1 << (k % 8), "latched line");
        end else begin
            i_wake_source_model.set_pin(1'b0);
            waitWake();
            i_wake_source_model.set_pin(1'b1);
        end
        i_wake_source_model.set_line(o, o == 8);
        i_wake_source_model.set_line(pos, pos == 8);
        apb(adr(suspend_wake_pkg::IDX_EVENT), 1'b1, 8'h40);
    endtask
    task automatic giveVerdict();
        $display("comparisons %0d mismatches %0d", nTests, errTotal);
        if (errTotal == 0 && nTests > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    // ========================================
    // Main sequence
    initial begin
        logic [7:0] v;
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        foreach (regIdx[i]) begin
            apb(adr(regIdx[i]), 1'b0, 8'h00);
            check(rd, 0, "reset value");
        end
        apb(12'h004, 1'b0, 8'h00);
        check({rdErr, rd[30:0]}, 32'h80000000, "unmapped read");
        apb(12'h0FD, 1'b1, 8'hFF);
        check(rdErr, 1, "misaligned write");
        $display("register reset test done");
        for (int i = 0; i < 4; i++) begin
            v = i < 2 ? 8'(i * 64) : 8'($random(seed));
            apb(adr(suspend_wake_pkg::IDX_MISC), 1'b1, v);
            apb(adr(suspend_wake_pkg::IDX_MISC), 1'b0, 8'h00);
            check(rd, v, "misc readback");
            @(negedge clk);
            check(shortRefreshPulse, v[6], "refresh pulse select");
        end
        $display("refresh pulse test done");
        for (int s = 0; s < 2; s++) begin
            apb(adr(suspend_wake_pkg::IDX_WAKE_SMI), 1'b1, 8'(s));
            enterSuspend();
            i_wake_source_model.set_pin(1'b0);
            waitWake();
            check({suspendActive, wakePmEvent}, 1, "pin wake");
            check(systemManagementInterrupt, s, "wake smi");
            apb(adr(suspend_wake_pkg::IDX_SOURCE), 1'b0, 8'h00);
            check(rd, 4, "pin source");
            apb(adr(suspend_wake_pkg::IDX_SUSPEND), 1'b0, 8'h00);
            check(rd, 2, "pending flag");
            check(irq, 0, "masked irq");
            apb(adr(suspend_wake_pkg::IDX_IRQ_MASK), 1'b1, 8'(s));
            @(negedge clk);
            check(irq, s, "unmasked irq");
            apb(adr(suspend_wake_pkg::IDX_IRQ_STATUS), 1'b1, 8'h03);
            @(negedge clk);
            check(irq, 0, "irq cleared");
            i_wake_source_model.set_pin(1'b1);
            apb(adr(suspend_wake_pkg::IDX_EVENT), 1'b1, 8'h40);
            @(negedge clk);
            check(wakePmEvent, 0, "event clear");
        end
        $display("pin wake test done");
        apb(adr(suspend_wake_pkg::IDX_EXTERNAL_PM_INTERRUPT_SMI), 1'b1, 8'h0F);
        apb(adr(suspend_wake_pkg::IDX_WAKE_SMI), 1'b1, 8'h00);
        groupCase(($random(seed) & 32'h7FFFFFFF) % 16, 1'b0);
        for (int k = 0; k < 16; k++) groupCase(k, 1'b1);
        $display("group wake test done");
        v = 8'($random(seed)) & 8'h0F;
        apb(adr(suspend_wake_pkg::IDX_RESUME_CTRL), 1'b1, 8'h10 | v);
        enterSuspend();
        repeat (v) i_wake_source_model.ring_toggle();
        @(negedge clk);
        check(suspendActive, 1, "ring below threshold");
        i_wake_source_model.ring_toggle();
        waitWake();
        check(suspendActive, 0, "ring wake");
        apb(adr(suspend_wake_pkg::IDX_SOURCE), 1'b0, 8'h00);
        check(rd, 1, "ring source");
        $display("ring wake test done");
        giveVerdict();
    end
endmodule

// [suspend_wake_pkg.sv]
// Register map, field positions and timing constants of the suspend wake logic
package suspend_wake_pkg;
    // ========================================
    // Register indices (byte address = 4 * index)
    localparam logic [9:0] IDX_MISC = 10'h03F;
    localparam logic [9:0] IDX_SUSPEND = 10'h050;
    localparam logic [9:0] IDX_EXTERNAL_PM_INTERRUPT_SMI = 10'h058;
    localparam logic [9:0] IDX_WAKE_SMI = 10'h059;
    localparam logic [9:0] IDX_EVENT = 10'h05C;
    localparam logic [9:0] IDX_RESUME_CTRL = 10'h05F;
    localparam logic [9:0] IDX_EN_LOW = 10'h06A;
    localparam logic [9:0] IDX_SOURCE = 10'h06B;
    localparam logic [9:0] IDX_EN_HIGH = 10'h0B1;
    localparam logic [9:0] IDX_IRQ_STATUS = 10'h0F0;
    localparam logic [9:0] IDX_IRQ_MASK = 10'h0F1;
    // ========================================
    // Field positions
    localparam int SHORT_PULSE_BIT = 6;
    localparam int GROUP_EN_BIT = 5;
    localparam int RING_EN_BIT = 4;
    localparam int START_SUSPEND_BIT = 0;
    localparam int PENDING_BIT = 1;
    localparam int WAKE_CLEAR_BIT = 6;
    localparam int WAKE_SMI_BIT = 0;
    localparam int SRC_RING_BIT = 0;
    localparam int SRC_GROUP_BIT = 1;
    localparam int SRC_PIN_BIT = 2;
    localparam int IRQ8_POS = 5;
    localparam int EVT_RESUME_BIT = 0;
    localparam int EVT_SUSPEND_BIT = 1;
    localparam int SYNC_PIN_POS = 17;
    localparam int SYNC_RING_POS = 16;
    // ========================================
    // Reset values
    localparam logic [7:0] RESET_BYTE = 8'h00;
    localparam logic [17:0] SYNC_INIT = 18'h20000;
    // ========================================
    // Timing
    localparam int CLK_HZ = 250_000_000;
    localparam int SAMPLE_HZ = 32_768;
    localparam int SAMPLE_DIV = CLK_HZ / SAMPLE_HZ;
    localparam int RING_HIGH_MS = 240;
    localparam int RING_LOW_MS = 60;
    // ========================================
    typedef enum logic {ST_ACTIVE, ST_SUSPENDED} power_state_t;
endpackage

// [suspend_wake_sva.sv]
// Port-level assertions for the suspend wake block
`timescale 1ns/1ns
module suspend_wake_sva (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // APB
    input wire logic [11:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // Wake pin and status
    input wire logic suspendWakePin_n,
    input wire logic suspendActive,
    input wire logic wakePmEvent,
    input wire logic shortRefreshPulse
);
    // ========================================
    // Decoded writes
    logic wrAcc, startWr, clrWr, pulseBit;
    assign wrAcc = psel && penable && pwrite;
    assign startWr = wrAcc && paddr == {suspend_wake_pkg::IDX_SUSPEND, 2'b00} && pwdata[0];
    assign clrWr = wrAcc && paddr == {suspend_wake_pkg::IDX_EVENT, 2'b00} && pwdata[6];
    assign pulseBit = pwdata[6];
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    // ========================================
    property p_short_pulse;
        wrAcc && paddr == {suspend_wake_pkg::IDX_MISC, 2'b00} |=> shortRefreshPulse == $past(pulseBit);
    endproperty
    a_short_pulse: assert property (p_short_pulse) else $error("refresh pulse select mismatch");
    property p_enter;
        startWr |=> suspendActive;
    endproperty
    a_enter: assert property (p_enter) else $error("suspend not entered");
    property p_stay_awake;
        !suspendActive && !startWr |=> !suspendActive;
    endproperty
    a_stay_awake: assert property (p_stay_awake) else $error("suspend without request");
    // Synchroniser plus one update edge stays well inside six cycles
    property p_pin_wake;
        suspendActive && $fell(suspendWakePin_n) |-> ##[1:6] !suspendActive;
    endproperty
    a_pin_wake: assert property (p_pin_wake) else $error("wake pin ignored");
    property p_rise_wake;
        $rose(wakePmEvent) |-> $fell(suspendActive);
    endproperty
    a_rise_wake: assert property (p_rise_wake) else $error("wake event without resume");
    property p_evt_clear;
        clrWr && !suspendActive |=> !wakePmEvent;
    endproperty
    a_evt_clear: assert property (p_evt_clear) else $error("wake event not cleared");
    property p_evt_hold;
        wakePmEvent && !clrWr |=> wakePmEvent;
    endproperty
    a_evt_hold: assert property (p_evt_hold) else $error("wake event dropped");
    property p_ready;
        psel && penable |-> pready;
    endproperty
    a_ready: assert property (p_ready) else $error("ready missing");
    property p_slverr;
        psel && penable && paddr[1:0] != 2'b00 |-> pslverr;
    endproperty
    a_slverr: assert property (p_slverr) else $error("misaligned access accepted");
    property p_upper;
        psel && penable && !pwrite |-> prdata[31:8] == 24'h000000;
    endproperty
    a_upper: assert property (p_upper) else $error("upper read bits set");
endmodule
bind suspend_wake suspend_wake_sva i_suspend_wake_sva (.clk(clk), .rst_n(rst_n), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .suspendWakePin_n(suspendWakePin_n), .suspendActive(suspendActive), .wakePmEvent(wakePmEvent),
    .shortRefreshPulse(shortRefreshPulse));

// [wake_source_model.sv]
// Far-side model driving interrupt lines, ring indicator and wake pin
`timescale 1ns/1ns
module wake_source_model #(
    parameter int HOLD_UNIT = 16
) (
    // Clock
    input wire logic clk,
    // Driven wake lines
    output logic [15:0] irqLine,
    output logic [3:0] externalPmInterrupt,
    output logic ringIndicatorInput,
    output logic suspendWakePin_n
);
    initial begin
        irqLine = 16'h0100;
        externalPmInterrupt = 4'h0;
        ringIndicatorInput = 1'b0;
        suspendWakePin_n = 1'b1;
    end
    // Positions 0-15 are IRQs, 16-19 external PM interrupts
    task automatic set_line(input int pos, input logic v);
        @(posedge clk);
        if (pos < 16) begin
            irqLine[pos] <= v;
        end else begin
            externalPmInterrupt[pos - 16] <= v;
        end
    endtask
    task automatic set_pin(input logic v);
        @(posedge clk);
        suspendWakePin_n <= v;
    endtask
    // High held four units, low one unit: the long/short hold ratio
    task automatic ring_toggle();
        @(posedge clk);
        ringIndicatorInput <= !ringIndicatorInput;
        repeat ((ringIndicatorInput ? 1 : 4) * HOLD_UNIT) @(posedge clk);
    endtask
endmodule
